// [modem_ctl_pkg.sv]
// shared constants for the modem control-line sequencer
package modem_ctl_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TICK_MS = 1;
   // cycles per 1 ms tick, derived from the clock rate
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned CD_WAIT_S = 60;
   localparam int unsigned DROP_S = 5;
   localparam int unsigned LOSS_S = 10;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned CD_WAIT_TICKS = CD_WAIT_S * MS_PER_S / TICK_MS;
   localparam int unsigned DROP_TICKS = DROP_S * MS_PER_S / TICK_MS;
   localparam int unsigned LOSS_TICKS = LOSS_S * MS_PER_S / TICK_MS;
   localparam int unsigned TIMER_W = 20;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CD_WAIT,
      ST_DROP,
      ST_UP
   } seq_state_e;
endpackage

// [tick_divider.sv]
// divider producing a one-cycle tick enable
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
   parameter int unsigned DIV = 100_000
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // tick enable
   output logic tick_o
);
   localparam int unsigned CW = $clog2(DIV);
   logic [CW-1:0] cnt_reg;
   wire cnt_wrap = (cnt_reg == CW'(DIV - 1));

   // free-running counter, tick on wrap
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_reg <= '0;
         tick_o <= 1'b0;
      end else begin
         cnt_reg <= cnt_wrap ? '0 : cnt_reg + CW'(1);
         tick_o <= cnt_wrap;
      end
   end
endmodule
`default_nettype wire

// [modem_ctl_seq.sv]
// modem control-line sequencer for a primary and a conditional secondary link
`timescale 1ns/1ps
`default_nettype none
module modem_ctl_seq
   import modem_ctl_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES,
   parameter int unsigned WAIT_TICKS = CD_WAIT_TICKS,
   parameter int unsigned DROP_T = DROP_TICKS,
   parameter int unsigned LOSS_T = LOSS_TICKS
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // modem status pins, asynchronous
   input wire logic ring_i,
   input wire logic cd_i,
   input wire logic dsr_i,
   input wire logic cts_i,
   // level 2 protocol
   input wire logic l2_timeout_i,
   input wire logic l2_can_send_i,
   // conditional link control
   input wire logic sec_activate_i,
   // modem control pins
   output logic dtr_o,
   output logic rts_o,
   output logic sec_dtr_o,
   output logic sec_rts_o,
   // status
   output logic link_up_o,
   output logic tx_enable_o,
   output logic alarm_o
);
   logic ring_m_reg, ring_s_reg, cd_m_reg, cd_s_reg, dsr_m_reg, dsr_s_reg;
   logic cts_m_reg, cts_s_reg;
   logic tick;
   seq_state_e state_reg, state_next;
   logic [TIMER_W-1:0] tmr_reg, tmr_next;
   logic [TIMER_W-1:0] loss_reg, loss_next;
   logic alarm_next;

   // two-flop synchronisers for modem pins
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         {ring_m_reg, cd_m_reg, dsr_m_reg, cts_m_reg} <= 4'h0;
         {ring_s_reg, cd_s_reg, dsr_s_reg, cts_s_reg} <= 4'h0;
      end else begin
         {ring_m_reg, cd_m_reg, dsr_m_reg, cts_m_reg} <= {ring_i, cd_i, dsr_i, cts_i};
         {ring_s_reg, cd_s_reg, dsr_s_reg, cts_s_reg} <=
            {ring_m_reg, cd_m_reg, dsr_m_reg, cts_m_reg};
      end
   end

   tick_divider #(.DIV(TICK_DIV)) i_tick_divider (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .tick_o(tick)
   );

   // decoded conditions
   wire both_up = cd_s_reg & dsr_s_reg;
   wire wait_done = tick && (tmr_reg >= TIMER_W'(WAIT_TICKS - 1));
   wire drop_done = tick && (tmr_reg >= TIMER_W'(DROP_T - 1));
   wire loss_done = tick && (loss_reg >= TIMER_W'(LOSS_T - 1));
   // full timer width, a bare wire would keep only bit 0
   wire [TIMER_W-1:0] tmr_inc = tick ? tmr_reg + TIMER_W'(1) : tmr_reg;

   // sequencing of the primary link
   always_comb begin
      state_next = state_reg;
      tmr_next = tmr_inc;
      unique case (state_reg)
         ST_IDLE: begin
            tmr_next = '0;
            if (ring_s_reg || cd_s_reg) begin
               state_next = ST_CD_WAIT;
            end
         end
         ST_CD_WAIT: begin
            if (both_up) begin
               state_next = ST_UP;
               tmr_next = '0;
            end else if (ring_s_reg) begin
               tmr_next = '0;
            end else if (wait_done) begin
               state_next = ST_DROP;
               tmr_next = '0;
            end
         end
         ST_DROP: begin
            // ring cuts the hold short so the call is answered at once
            if (ring_s_reg || drop_done) begin
               state_next = ST_CD_WAIT;
               tmr_next = '0;
            end
         end
         ST_UP: begin
            tmr_next = '0; // ring is not looked at here
            if (l2_timeout_i) begin
               state_next = ST_DROP;
            end
         end
         default: begin
            state_next = ST_IDLE;
            tmr_next = '0;
         end
      endcase
      if (state_reg != ST_UP && state_reg != ST_IDLE && l2_timeout_i
          && state_reg != ST_DROP) begin
         state_next = ST_DROP;
         tmr_next = '0;
      end
   end

   // carrier-loss glitch filter; short dropouts reset the count
   always_comb begin
      loss_next = '0;
      alarm_next = alarm_o;
      if (state_reg == ST_UP) begin
         if (cd_s_reg) begin
            loss_next = '0;
         end else if (!alarm_o) begin
            loss_next = tick ? loss_reg + TIMER_W'(1) : loss_reg;
            if (loss_done) begin
               alarm_next = 1'b1;
            end
         end
         if (cd_s_reg) begin
            alarm_next = 1'b0;
         end
      end else begin
         alarm_next = 1'b0;
      end
   end

   // state, timers and registered outputs
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_IDLE;
         tmr_reg <= '0;
         loss_reg <= '0;
         alarm_o <= 1'b0;
         dtr_o <= 1'b0;
         rts_o <= 1'b0;
         sec_dtr_o <= 1'b0;
         sec_rts_o <= 1'b0;
         link_up_o <= 1'b0;
         tx_enable_o <= 1'b0;
      end else begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
         loss_reg <= loss_next;
         alarm_o <= alarm_next;
         dtr_o <= (state_next == ST_CD_WAIT) || (state_next == ST_UP);
         rts_o <= (state_next == ST_CD_WAIT) || (state_next == ST_UP);
         sec_dtr_o <= sec_activate_i;
         sec_rts_o <= sec_activate_i;
         link_up_o <= (state_next == ST_UP);
         // cts plays no part; l2 keeps sending while it can
         tx_enable_o <= (state_next == ST_UP) && l2_can_send_i;
      end
   end

   // assertions
   AST_RESET_LOW: assert property (
      @(posedge clock_i) $fell(sys_rst_i) |-> !dtr_o && !rts_o)
      else $error("lines not low after reset");
   AST_RING_RAISE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == ST_IDLE && ring_s_reg |=> dtr_o && rts_o)
      else $error("ring did not raise dtr");
   AST_LEASED: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == ST_IDLE && cd_s_reg |=> dtr_o && rts_o)
      else $error("carrier did not raise dtr");
   AST_WAIT_DROP: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == ST_CD_WAIT && wait_done && !both_up && !ring_s_reg && !l2_timeout_i
      |=> !dtr_o && !rts_o)
      else $error("wait expiry did not drop dtr");
   AST_DROP_RING: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == ST_DROP && ring_s_reg |=> dtr_o && tmr_reg == '0)
      else $error("ring in drop not answered");
   AST_RESTART: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == ST_CD_WAIT && ring_s_reg && !both_up && !l2_timeout_i |=> tmr_reg == '0)
      else $error("ring did not restart wait");
   AST_UP_BOTH: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      $rose(link_up_o) |-> $past(both_up))
      else $error("link up without cd and dsr");
   AST_L2_TO: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == ST_UP && l2_timeout_i |=> !dtr_o)
      else $error("l2 timeout did not toggle dtr");
   AST_ALARM_CAUSE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      $rose(alarm_o) |-> !$past(cd_s_reg) && $past(loss_done))
      else $error("alarm without full carrier loss");
   AST_SEC: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      1'b1 |=> sec_dtr_o == $past(sec_activate_i) && sec_rts_o == sec_dtr_o)
      else $error("secondary lines wrong");
   // a low cts must never hold transmit back while the link is up
   AST_NO_CTS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      state_reg == ST_UP && !l2_timeout_i && l2_can_send_i && !cts_s_reg |=> tx_enable_o)
      else $error("transmit gated by cts");
   COV_UP: cover property (@(posedge clock_i) $rose(link_up_o));
   COV_DROP: cover property (@(posedge clock_i) state_reg == ST_DROP);
   COV_ALARM: cover property (@(posedge clock_i) $rose(alarm_o));
endmodule
`default_nettype wire

// [modem_model.sv]
// behavioural modem facing the primary link control lines
`timescale 1ns/1ps
`default_nettype none
module modem_model (
   // clock
   input wire logic clock_i,
   // control lines from the sequencer
   input wire logic dtr_i,
   input wire logic rts_i,
   // scenario controls
   input wire logic call_i,
   input wire logic answer_i,
   input wire logic line_ok_i,
   input wire logic leased_i,
   // modem status lines
   output logic ring_o,
   output logic cd_o,
   output logic dsr_o,
   output logic cts_o
);
   logic [2:0] up_cnt = 3'h0;
   // ring follows an incoming call for as long as the caller holds on
   assign ring_o = call_i;
   // cts kept low so that any flow gating on it would show
   assign cts_o = 1'b0;
   // carrier needs an intact line, dsr only an established call
   // a leased dataset shows both at once, with no ring and no dtr needed
   assign cd_o = leased_i || ((up_cnt == 3'h7) && line_ok_i);
   assign dsr_o = leased_i || (up_cnt == 3'h7);
   // low dtr or rts hangs up at once, a later raise dials again
   always_ff @(posedge clock_i) begin
      if (!(dtr_i && rts_i) || !answer_i) begin
         up_cnt <= 3'h0;
      end else if (up_cnt != 3'h7) begin
         up_cnt <= up_cnt + 3'h1;
      end
   end
endmodule
`default_nettype wire

// [tb_wan_modem_control_sequencer.sv]
// self-checking bench for the modem control-line sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_wan_modem_control_sequencer;
   import modem_ctl_pkg::*;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic call = 1'b0, answer = 1'b0, line_ok = 1'b1;
   logic l2_to = 1'b0, can_send = 1'b1, sec_act = 1'b0;
   logic leased = 1'b0;
   logic ring, cd, dsr, cts, dtr, rts, sec_dtr, sec_rts, link_up, tx_en, alarm;
   int fail_count = 0;
   int check_count = 0;
   // short counts: tick 4 cycles, wait 80, drop 32, loss 40 cycles
   modem_ctl_seq #(.TICK_DIV(4), .WAIT_TICKS(20), .DROP_T(8), .LOSS_T(10)) i_modem_ctl_seq (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ring_i(ring), .cd_i(cd), .dsr_i(dsr),
      .cts_i(cts), .l2_timeout_i(l2_to), .l2_can_send_i(can_send),
      .sec_activate_i(sec_act), .dtr_o(dtr), .rts_o(rts), .sec_dtr_o(sec_dtr),
      .sec_rts_o(sec_rts), .link_up_o(link_up), .tx_enable_o(tx_en), .alarm_o(alarm));
   modem_model i_modem_model (.clock_i(clock_i), .dtr_i(dtr), .rts_i(rts), .call_i(call),
      .answer_i(answer), .line_ok_i(line_ok), .ring_o(ring), .cd_o(cd), .dsr_o(dsr),
      .cts_o(cts), .leased_i(leased));
   // 100 MHz clock
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   // edges only; drives follow at the edge, checks after a settle step
   task cyc(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task look(input int n);
      cyc(n);
      #1;
   endtask
   task chk(input string nm, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task test_done();
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // lines stay low after reset while no call is offered
   task t_reset();
      look(10);
      chk("dtr idle", 1'b0, dtr);
      chk("rts idle", 1'b0, rts);
      chk("link idle", 1'b0, link_up);
   endtask
   // incoming call answered, link up once cd and dsr both high
   task t_answer();
      cyc(1);
      call <= 1'b1;
      answer <= 1'b1;
      look(3);
      chk("dtr on ring", 1'b1, dtr);
      chk("rts on ring", 1'b1, rts);
      chk("link early", 1'b0, link_up);
      look(12);
      chk("link up", 1'b1, link_up);
      chk("tx with cts low", 1'b1, tx_en);
      look(30);
      chk("ring ignored up", 1'b1, dtr);
      cyc(1);
      call <= 1'b0;
   endtask
   // short dropout ignored, long one alarms but keeps sending
   task t_glitch();
      cyc(1);
      line_ok <= 1'b0;
      cyc(20);
      line_ok <= 1'b1;
      look(40);
      chk("glitch alarm", 1'b0, alarm);
      cyc(1);
      line_ok <= 1'b0;
      look(30);
      chk("alarm early", 1'b0, alarm);
      look(20);
      chk("alarm late", 1'b1, alarm);
      chk("tx after loss", 1'b1, tx_en);
      cyc(1);
      line_ok <= 1'b1;
      answer <= 1'b0;
   endtask
   // level 2 timeout starts dtr toggling with an unanswering modem
   task t_toggle();
      cyc(1);
      l2_to <= 1'b1;
      cyc(1);
      l2_to <= 1'b0;
      look(3);
      chk("dtr on l2 timeout", 1'b0, dtr);
      chk("rts on l2 timeout", 1'b0, rts);
      look(24);
      chk("dtr held low", 1'b0, dtr);
      look(16);
      chk("dtr raised again", 1'b1, dtr);
      look(60);
      chk("dtr in wait", 1'b1, dtr);
      look(22);
      chk("dtr after wait", 1'b0, dtr);
      cyc(1);
      call <= 1'b1;
      look(4);
      chk("ring during drop", 1'b1, dtr);
      cyc(1);
      call <= 1'b0;
      // a short ring mid-wait pushes the expiry about 40 cycles out
      cyc(40);
      call <= 1'b1;
      cyc(1);
      call <= 1'b0;
      look(60);
      chk("ring restarts wait", 1'b1, dtr);
      look(30);
      chk("restarted wait ends", 1'b0, dtr);
   endtask
   // mid-run reset, then a leased line answers on carrier alone
   task t_leased();
      cyc(1);
      sys_rst_i <= 1'b1;
      leased <= 1'b1;
      cyc(2);
      sys_rst_i <= 1'b0;
      look(1);
      chk("dtr after reset", 1'b0, dtr);
      chk("link after reset", 1'b0, link_up);
      look(4);
      chk("dtr on carrier", 1'b1, dtr);
      chk("rts on carrier", 1'b1, rts);
      chk("link on leased", 1'b1, link_up);
      cyc(1);
      can_send <= 1'b0;
      look(2);
      chk("tx stops with l2", 1'b0, tx_en);
      cyc(1);
      can_send <= 1'b1;
      look(2);
      chk("tx resumes", 1'b1, tx_en);
   endtask
   // secondary link follows its activation request
   task t_secondary();
      look(1);
      chk("sec dtr idle", 1'b0, sec_dtr);
      chk("sec rts idle", 1'b0, sec_rts);
      cyc(1);
      sec_act <= 1'b1;
      look(3);
      chk("sec dtr on", 1'b1, sec_dtr);
      chk("sec rts on", 1'b1, sec_rts);
      cyc(1);
      sec_act <= 1'b0;
      look(2);
      chk("sec dtr off", 1'b0, sec_dtr);
      chk("sec rts off", 1'b0, sec_rts);
   endtask
   // main sequence after a six-cycle reset
   initial begin
      cyc(6);
      sys_rst_i <= 1'b0;
      t_reset();
      t_answer();
      t_glitch();
      t_toggle();
      t_leased();
      t_secondary();
      test_done();
   end
   // watchdog well beyond the roughly 500 cycles of the run
   initial begin
      cyc(5000);
      fail_count++;
      test_done();
   end
endmodule
`default_nettype wire
